// ---- design/cprc_defs.svh ----
// Timing, address and reset-value constants for clock, power and reset control.
// Assumes one 200 MHz oscillator-rate clock; counts are in oscillator periods.
`ifndef CPRC_DEFS_SVH
`define CPRC_DEFS_SVH

// Twelve oscillator periods per machine cycle
`define CPRC_OSC_PER_MC 4'hc
`define CPRC_CNT_FIRST 4'h0
`define CPRC_CNT_LAST 4'hb
`define CPRC_CNT_STEP 4'h1
// Half machine cycle: one latch strobe slot
`define CPRC_HALF_MC 4'h6
`define CPRC_ALE_WIDTH 4'h2
`define CPRC_PROG_STORE_STROBE_N_FIRST 4'h2
`define CPRC_PROG_STORE_STROBE_N_LAST 4'h4
// State 5, phase 2 as a count
`define CPRC_STATE5_PHASE2_CNT 4'h9

`define CPRC_POWER_CONTROL_REG_ADDR 8'h87
`define CPRC_SP_ADDR 8'h81
`define CPRC_SERIAL_DATA_BUFFER_ADDR 8'h99
// Port latch addresses, port 0 in the low byte
`define CPRC_PORT_ADDRS 32'hb0a09080
`define CPRC_NUM_PORTS 4

`define CPRC_PORT_RST 8'hff
`define CPRC_SP_RST 8'h07
`define CPRC_ZERO8 8'h00
`define CPRC_HIST_SET 2'h3
`define CPRC_HIST_CLR 2'h0

// Power control request bits and reset values; pin drives are {o, oe_n}
`define CPRC_IDL_BIT 0
`define CPRC_PD_BIT 1
`define CPRC_POWER_CONTROL_REG_RST 8'h10
`define CPRC_ALE_DRV_RST 2'h1
`define CPRC_PROG_STORE_STROBE_N_DRV_RST 2'h3

`endif

// ---- design/cprc_pkg.sv ----
// Types shared by clock, power and reset control.
// Assumes cprc_defs.svh is included by the users of these types.
package cprc_pkg;

    typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_PDOWN} cprc_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cprc_bus_req_t;

    typedef struct packed {
        logic smod;
        logic [1:0] rsvd;
        logic power_off_flag;
        logic gf1;
        logic gf0;
        logic powerdown_request_bit;
        logic idle_request_bit;
    } cprc_power_control_reg_t;

    // Two-way pin drive; oe_n low while driving
    typedef struct packed {
        logic o;
        logic oe_n;
    } cprc_pin_drv_t;

endpackage : cprc_pkg

// ---- design/cprc_top.sv ----
// Clock division, external memory strobes, idle/power-down and reset control.
// Assumes clk is the oscillator input and rst_pin is synchronous to it.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "cprc_defs.svh"

module cprc_top (
    input wire logic clk, // Oscillator clock
    input wire logic reset_n, // Power-on reset
    input wire cprc_pkg::cprc_bus_req_t bus_req, // Register access
    output logic [7:0] bus_rdata, // Read data, cycle after read
    input wire logic rst_pin, // Reset pin level
    input wire logic flash_mode, // Flash writer mode
    input wire logic irq, // Any pending interrupt
    input wire logic xdata_req, // External data access start pulse
    input wire logic code_fetch, // External fetch or table read
    input wire logic ale_i, // Latch strobe pin level
    output cprc_pkg::cprc_pin_drv_t ale_drv, // Latch strobe drive
    input wire logic prog_store_strobe_n_i, // Program strobe pin level
    output cprc_pkg::cprc_pin_drv_t prog_store_strobe_n_drv, // Program strobe drive
    output logic flash_ale_sel, // Writer pattern bit from latch pin
    output logic flash_prog_store_strobe_n_sel, // Writer pattern bit from program pin
    output logic sys_reset, // Filtered internal reset
    output logic cpu_clk_en, // Processor clock gate
    output logic periph_clk_en, // Peripheral clock gate
    output logic osc_en, // Oscillator enable
    output logic [3:0] cycle_count, // Oscillator count in machine cycle
    output logic state5_phase2, // Reset sample point
    output logic [31:0] port_latch, // Port latches
    output logic [7:0] stack_ptr // Stack pointer
);

    function automatic logic [3:0] half_pos(input logic [3:0] cnt);
        half_pos = (cnt < `CPRC_HALF_MC) ? cnt : cnt - `CPRC_HALF_MC;
    endfunction : half_pos

    ////////////////////////////////////////////////////////////////////////////
    cprc_pkg::cprc_mode_t mode, next_mode;
    cprc_pkg::cprc_power_control_reg_t power_control_reg, next_power_control_reg;
    cprc_pkg::cprc_pin_drv_t next_ale_drv, next_prog_store_strobe_n_drv;
    logic [3:0] next_count;
    logic skip_pend, next_skip_pend, skipping, next_skipping;
    logic [1:0] hist, next_hist;
    logic next_sys_reset, next_flash_ale_sel, next_flash_prog_store_strobe_n_sel;
    logic [7:0] next_stack_ptr, next_rdata, serial_data_buffer, next_serial_data_buffer;
    logic running, slot_start, wr_power_control_reg, wr_ok;
    localparam logic [31:0] port_addrs = `CPRC_PORT_ADDRS;

    assign running = (mode != cprc_pkg::MODE_PDOWN);
    assign state5_phase2 = running && (cycle_count == `CPRC_STATE5_PHASE2_CNT);
    assign cpu_clk_en = (mode == cprc_pkg::MODE_RUN);
    assign periph_clk_en = running;
    assign osc_en = running;
    assign wr_ok = bus_req.wr && !sys_reset;
    assign wr_power_control_reg = wr_ok && (bus_req.addr == `CPRC_POWER_CONTROL_REG_ADDR);
    assign slot_start = running && (half_pos(cycle_count) == `CPRC_CNT_FIRST);

    always_comb
    begin
        next_count = cycle_count;
        if (running)
        begin
            // Count LSB is the divide-by-two phase
            next_count = (cycle_count == `CPRC_CNT_LAST) ? `CPRC_CNT_FIRST
                : cycle_count + `CPRC_CNT_STEP;
        end
        // Request arriving at the consuming slot stays pending
        next_skip_pend = xdata_req || (skip_pend && !slot_start);
        next_skipping = slot_start ? skip_pend : skipping;

        next_hist = hist;
        next_sys_reset = sys_reset;
        if (state5_phase2)
        begin
            next_hist = {hist[0], rst_pin};
            // Two agreeing samples needed either way: glitch filter and hysteresis
            if ({hist[0], rst_pin} == `CPRC_HIST_SET)
                next_sys_reset = 1'b1;
            else if ({hist[0], rst_pin} == `CPRC_HIST_CLR)
                next_sys_reset = 1'b0;
        end

        next_mode = mode;
        if (sys_reset)
            next_mode = cprc_pkg::MODE_RUN;
        else
        begin
            case (mode)
                cprc_pkg::MODE_RUN:
                begin
                    if (wr_power_control_reg && bus_req.wdata[`CPRC_PD_BIT])
                        next_mode = cprc_pkg::MODE_PDOWN;
                    else if (wr_power_control_reg && bus_req.wdata[`CPRC_IDL_BIT])
                        next_mode = cprc_pkg::MODE_IDLE;
                end
                cprc_pkg::MODE_IDLE:
                begin
                    if (irq)
                        next_mode = cprc_pkg::MODE_RUN;
                end
                cprc_pkg::MODE_PDOWN:
                begin
                    // Counter is frozen, so wake straight into reset
                    if (rst_pin)
                    begin
                        next_mode = cprc_pkg::MODE_RUN;
                        next_sys_reset = 1'b1;
                        next_hist = `CPRC_HIST_SET;
                    end
                end
                default: next_mode = cprc_pkg::MODE_RUN;
            endcase
        end

        next_power_control_reg = power_control_reg;
        next_stack_ptr = stack_ptr;
        next_serial_data_buffer = serial_data_buffer;
        if (sys_reset)
        begin
            next_power_control_reg = `CPRC_ZERO8;
            next_power_control_reg.power_off_flag = power_control_reg.power_off_flag;
            next_stack_ptr = `CPRC_SP_RST;
        end
        else
        begin
            if (wr_power_control_reg)
            begin
                next_power_control_reg = bus_req.wdata;
                next_power_control_reg.rsvd = 2'h0;
                next_power_control_reg.idle_request_bit = 1'b0;
                next_power_control_reg.powerdown_request_bit = 1'b0;
            end
            if (wr_ok && bus_req.addr == `CPRC_SP_ADDR)
                next_stack_ptr = bus_req.wdata;
        end
        // Serial buffer survives reset
        if (bus_req.wr && bus_req.addr == `CPRC_SERIAL_DATA_BUFFER_ADDR)
            next_serial_data_buffer = bus_req.wdata;

        next_ale_drv.oe_n = sys_reset || flash_mode;
        next_ale_drv.o = !sys_reset && !flash_mode && running
            && (half_pos(cycle_count) < `CPRC_ALE_WIDTH) && !next_skipping;
        next_prog_store_strobe_n_drv.oe_n = sys_reset || flash_mode;
        next_prog_store_strobe_n_drv.o = !(!sys_reset && !flash_mode && code_fetch
            && cpu_clk_en && half_pos(cycle_count) >= `CPRC_PROG_STORE_STROBE_N_FIRST
            && half_pos(cycle_count) <= `CPRC_PROG_STORE_STROBE_N_LAST);
        next_flash_ale_sel = flash_mode && !ale_i;
        next_flash_prog_store_strobe_n_sel = flash_mode && prog_store_strobe_n_i;

        next_rdata = `CPRC_ZERO8;
        if (bus_req.rd)
        begin
            if (bus_req.addr == `CPRC_POWER_CONTROL_REG_ADDR)
            begin
                next_rdata = power_control_reg;
                next_rdata[`CPRC_IDL_BIT] = (mode == cprc_pkg::MODE_IDLE);
                next_rdata[`CPRC_PD_BIT] = (mode == cprc_pkg::MODE_PDOWN);
            end
            if (bus_req.addr == `CPRC_SP_ADDR)
                next_rdata = stack_ptr;
            if (bus_req.addr == `CPRC_SERIAL_DATA_BUFFER_ADDR)
                next_rdata = serial_data_buffer;
            for (int i = 0; i < `CPRC_NUM_PORTS; i++)
            begin
                if (bus_req.addr == port_addrs[i*8 +: 8])
                    next_rdata = port_latch[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode <= cprc_pkg::MODE_RUN;
            power_control_reg <= `CPRC_POWER_CONTROL_REG_RST;
            cycle_count <= `CPRC_CNT_FIRST;
            skip_pend <= 1'b0;
            skipping <= 1'b0;
            hist <= `CPRC_HIST_CLR;
            sys_reset <= 1'b0;
            stack_ptr <= `CPRC_SP_RST;
            ale_drv <= `CPRC_ALE_DRV_RST;
            prog_store_strobe_n_drv <= `CPRC_PROG_STORE_STROBE_N_DRV_RST;
            flash_ale_sel <= 1'b0;
            flash_prog_store_strobe_n_sel <= 1'b0;
            bus_rdata <= `CPRC_ZERO8;
        end
        else
        begin
            mode <= next_mode;
            power_control_reg <= next_power_control_reg;
            cycle_count <= next_count;
            skip_pend <= next_skip_pend;
            skipping <= next_skipping;
            hist <= next_hist;
            sys_reset <= next_sys_reset;
            stack_ptr <= next_stack_ptr;
            ale_drv <= next_ale_drv;
            prog_store_strobe_n_drv <= next_prog_store_strobe_n_drv;
            flash_ale_sel <= next_flash_ale_sel;
            flash_prog_store_strobe_n_sel <= next_flash_prog_store_strobe_n_sel;
            bus_rdata <= next_rdata;
        end
    end

    // Data register only; no reset by design
    always_ff @(posedge clk)
    begin
        serial_data_buffer <= next_serial_data_buffer;
    end

    ////////////////////////////////////////////////////////////////////////////
    genvar gp;
    generate
        for (gp = 0; gp < `CPRC_NUM_PORTS; gp++)
        begin : g_port
            logic [7:0] next_latch;
            always_comb
            begin
                next_latch = port_latch[gp*8 +: 8];
                if (sys_reset)
                    next_latch = `CPRC_PORT_RST;
                else if (wr_ok && bus_req.addr == port_addrs[gp*8 +: 8])
                    next_latch = bus_req.wdata;
            end
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    port_latch[gp*8 +: 8] <= `CPRC_PORT_RST;
                else
                    port_latch[gp*8 +: 8] <= next_latch;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_count_wrap;
        running && cycle_count == `CPRC_CNT_LAST |=> cycle_count == `CPRC_CNT_FIRST;
    endproperty
    a_count_wrap: assert property (p_count_wrap) else $error("count wrap");
    property p_phase_toggle;
        running |=> cycle_count[0] != $past(cycle_count[0]);
    endproperty
    a_phase_toggle: assert property (p_phase_toggle) else $error("phase stuck");
    property p_ale_rate;
        ale_drv.o && !skipping && !sys_reset && !flash_mode && running
            |-> ##6 (ale_drv.o || skipping || sys_reset || flash_mode || !running);
    endproperty
    a_ale_rate: assert property (p_ale_rate) else $error("strobe period");
    property p_ale_skip;
        slot_start && skip_pend |=> !ale_drv.o [*2];
    endproperty
    a_ale_skip: assert property (p_ale_skip) else $error("pulse not skipped");
    property p_ale_release;
        sys_reset |=> ale_drv.oe_n;
    endproperty
    a_ale_release: assert property (p_ale_release) else $error("latch pin driven");
    property p_prog_store_strobe_n_fetch;
        !prog_store_strobe_n_drv.o |-> $past(code_fetch) && !prog_store_strobe_n_drv.oe_n;
    endproperty
    a_prog_store_strobe_n_fetch: assert property (p_prog_store_strobe_n_fetch) else $error("stray strobe");
    property p_prog_store_strobe_n_release;
        sys_reset |=> prog_store_strobe_n_drv.oe_n && prog_store_strobe_n_drv.o;
    endproperty
    a_prog_store_strobe_n_release: assert property (p_prog_store_strobe_n_release) else $error("store pin driven");
    property p_flash_ale;
        flash_mode |=> ale_drv.oe_n && flash_ale_sel == !$past(ale_i);
    endproperty
    a_flash_ale: assert property (p_flash_ale) else $error("flash latch pin");
    property p_flash_prog_store_strobe_n;
        flash_mode |=> prog_store_strobe_n_drv.oe_n && flash_prog_store_strobe_n_sel == $past(prog_store_strobe_n_i);
    endproperty
    a_flash_prog_store_strobe_n: assert property (p_flash_prog_store_strobe_n) else $error("flash store pin");
    property p_idle_enter;
        wr_power_control_reg && bus_req.wdata[0] && !bus_req.wdata[1] && mode == cprc_pkg::MODE_RUN
            |=> !cpu_clk_en && periph_clk_en;
    endproperty
    a_idle_enter: assert property (p_idle_enter) else $error("idle entry");
    property p_idle_wake;
        mode == cprc_pkg::MODE_IDLE && irq |=> cpu_clk_en;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake");
    property p_pd_enter;
        wr_power_control_reg && bus_req.wdata[1] && mode == cprc_pkg::MODE_RUN |=> !osc_en && !periph_clk_en;
    endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("power-down entry");
    property p_pd_hold;
        mode == cprc_pkg::MODE_PDOWN && !rst_pin |=> mode == cprc_pkg::MODE_PDOWN;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("power-down left");
    property p_rst_take;
        state5_phase2 && rst_pin && hist[0] |=> sys_reset;
    endproperty
    a_rst_take: assert property (p_rst_take) else $error("reset missed");
    property p_rst_glitch;
        !sys_reset && !(state5_phase2 && rst_pin) && mode != cprc_pkg::MODE_PDOWN
            |=> !sys_reset;
    endproperty
    a_rst_glitch: assert property (p_rst_glitch) else $error("glitch reset");
    property p_rst_values;
        sys_reset |=> port_latch == {`CPRC_NUM_PORTS{`CPRC_PORT_RST}} && stack_ptr == `CPRC_SP_RST;
    endproperty
    a_rst_values: assert property (p_rst_values) else $error("reset values");
    property p_pof_keep;
        sys_reset |=> power_control_reg.power_off_flag == $past(power_control_reg.power_off_flag) && !power_control_reg.gf0;
    endproperty
    a_pof_keep: assert property (p_pof_keep) else $error("power-off flag");

    c_skip: cover property (slot_start && skip_pend ##1 !ale_drv.o);
    c_idle: cover property (mode == cprc_pkg::MODE_IDLE ##1 irq ##1 cpu_clk_en);
    c_pd: cover property (mode == cprc_pkg::MODE_PDOWN ##1 rst_pin ##1 sys_reset);
    c_flash: cover property (flash_mode && flash_ale_sel && flash_prog_store_strobe_n_sel);

endmodule : cprc_top

// ---- verification/cprc_ext_mem.sv ----
// Address latch and external program memory model at the strobe pins.
// Assumes {o, oe_n} pin drives and pull-ups on both strobe pins.
`timescale 1ns/1ps

module cprc_ext_mem (
    input wire logic clk, // Oscillator clock
    input wire cprc_pkg::cprc_pin_drv_t ale_drv, // Latch strobe drive
    input wire cprc_pkg::cprc_pin_drv_t prog_store_strobe_n_drv, // Program strobe drive
    input wire logic flash_mode, // Writer owns the strobe pins
    input wire logic wr_ale, // Writer level on latch pin
    input wire logic wr_prog_store_strobe_n, // Writer level on program pin
    output logic ale_i, // Latch pin wire level
    output logic prog_store_strobe_n_i, // Program pin wire level
    output logic [7:0] p0_bus // Low-order bus from memory
);
    logic [7:0] addr_lat = 8'h00;
    logic [7:0] drv_p0 = 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // Writer drives only in flash mode; otherwise pull-up when released
    assign ale_i = flash_mode ? wr_ale : (ale_drv.oe_n ? 1'b1 : ale_drv.o);
    assign prog_store_strobe_n_i = flash_mode ? wr_prog_store_strobe_n : (prog_store_strobe_n_drv.oe_n ? 1'b1 : prog_store_strobe_n_drv.o);
    ////////////////////////////////////////////////////////////////////////////
    // Released bus shows the inverse of the last data, so stale data never looks valid
    always_ff @(posedge clk)
    begin
        if (ale_i)
            addr_lat <= addr_lat + 8'h01;
        if (!prog_store_strobe_n_i)
        begin
            p0_bus <= addr_lat ^ 8'h5a;
            drv_p0 <= addr_lat ^ 8'h5a;
        end
        else
            p0_bus <= ~drv_p0;
    end
endmodule : cprc_ext_mem

// ---- verification/clock_power_reset_control_tb.sv ----
// Self-checking bench for clock, power and reset control.
// Assumes cprc_top and the external memory model; 200 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module clock_power_reset_control_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    cprc_pkg::cprc_bus_req_t bus_req = '0;
    logic rst_pin = 1'b0;
    logic flash_mode = 1'b0;
    logic irq = 1'b0;
    logic xdata_req = 1'b0;
    logic code_fetch = 1'b0;
    logic wr_ale = 1'b1;
    logic wr_prog_store_strobe_n = 1'b0;
    logic rd_d = 1'b0;
    logic ale_i, prog_store_strobe_n_i, flash_ale_sel, flash_prog_store_strobe_n_sel, sys_reset;
    logic cpu_clk_en, periph_clk_en, osc_en, state5_phase2;
    logic [7:0] bus_rdata, stack_ptr, p0_bus, serial_data_buffer_val, mon_e;
    logic [3:0] cycle_count, c0;
    logic [31:0] port_latch, port_val;
    cprc_pkg::cprc_pin_drv_t ale_drv, prog_store_strobe_n_drv;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int n_checks = 0;
    int cnt;

    cprc_top dut (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .rst_pin(rst_pin), .flash_mode(flash_mode), .irq(irq), .xdata_req(xdata_req),
        .code_fetch(code_fetch), .ale_i(ale_i), .ale_drv(ale_drv), .prog_store_strobe_n_i(prog_store_strobe_n_i),
        .prog_store_strobe_n_drv(prog_store_strobe_n_drv), .flash_ale_sel(flash_ale_sel), .flash_prog_store_strobe_n_sel(flash_prog_store_strobe_n_sel),
        .sys_reset(sys_reset), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .osc_en(osc_en), .cycle_count(cycle_count), .state5_phase2(state5_phase2),
        .port_latch(port_latch), .stack_ptr(stack_ptr));

    cprc_ext_mem u_mem (.clk(clk), .ale_drv(ale_drv), .prog_store_strobe_n_drv(prog_store_strobe_n_drv),
        .flash_mode(flash_mode), .wr_ale(wr_ale), .wr_prog_store_strobe_n(wr_prog_store_strobe_n), .ale_i(ale_i),
        .prog_store_strobe_n_i(prog_store_strobe_n_i), .p0_bus(p0_bus));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        exp_q.push_back(e);
        @(posedge clk);
        bus_req <= '0;
    endtask : rd

    // Counts high latch-pin cycles, or low program-pin cycles
    task automatic count_hi(input int n, input logic ale, output int c);
        c = 0;
        repeat (n)
        begin
            tick(1);
            if (ale ? ale_i : !prog_store_strobe_n_i)
                c++;
        end
    endtask : count_hi

    task automatic wait_rst(input logic v);
        for (int i = 0; i < 100 && sys_reset !== v; i++)
            tick(1);
        if (sys_reset !== v)
        begin
            err_count++;
            results();
        end
    endtask : wait_rst

    task automatic results;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the read strobe
    always @(posedge clk)
    begin
        rd_d <= bus_req.rd;
        if (rd_d)
        begin
            mon_e = exp_q.pop_front();
            `CHK(bus_rdata, mon_e)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(80));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        tick(2);
        `CHK(port_latch, 32'hffffffff)
        `CHK(stack_ptr, 8'h07)
        for (int k = 0; k < 4; k++)
            rd(8'h80 + 8'(k * 16), 8'hff);
        rd(8'h81, 8'h07);
        rd(8'h87, 8'h10);
        rd(8'h5e, 8'h00);
        port_val = $urandom();
        serial_data_buffer_val = 8'($urandom());
        for (int k = 0; k < 4; k++)
            wr(8'h80 + 8'(k * 16), port_val[k * 8 +: 8]);
        wr(8'h81, 8'h3c);
        wr(8'h99, serial_data_buffer_val);
        wr(8'h87, 8'h00);
        tick(1);
        `CHK(port_latch, port_val)
        rd(8'h81, 8'h3c);
        rd(8'h87, 8'h00);
        // Phase and state count
        tick(0);
        c0 = cycle_count;
        for (int k = 1; k <= 24; k++)
        begin
            tick(1);
            `CHK(cycle_count, 4'((c0 + k) % 12))
            `CHK(state5_phase2, ((c0 + k) % 12) == 9)
        end
        count_hi(60, 1'b1, cnt);
        `CHK(cnt, 20)
        @(posedge clk);
        code_fetch <= 1'b1;
        tick(12);
        count_hi(60, 1'b0, cnt);
        `CHK(cnt, 30)
        @(posedge clk);
        xdata_req <= 1'b1;
        @(posedge clk);
        xdata_req <= 1'b0;
        count_hi(60, 1'b1, cnt);
        `CHK(cnt, 18)
        // One-cycle glitch must not reset
        @(posedge clk);
        rst_pin <= 1'b1;
        @(posedge clk);
        rst_pin <= 1'b0;
        for (int k = 0; k < 30; k++)
        begin
            tick(1);
            `CHK(sys_reset, 1'b0)
        end
        @(posedge clk);
        rst_pin <= 1'b1;
        wait_rst(1'b1);
        tick(1);
        `CHK(ale_drv.oe_n, 1'b1)
        `CHK(prog_store_strobe_n_drv.oe_n, 1'b1)
        `CHK(ale_i, 1'b1)
        `CHK(port_latch, 32'hffffffff)
        wr(8'h80, 8'h55);
        wr(8'h99, ~serial_data_buffer_val);
        tick(36);
        @(posedge clk);
        rst_pin <= 1'b0;
        wait_rst(1'b0);
        tick(1);
        `CHK(ale_drv.oe_n, 1'b0)
        rd(8'h80, 8'hff);
        rd(8'h81, 8'h07);
        rd(8'h99, ~serial_data_buffer_val);
        rd(8'h87, 8'h00);
        // Idle and wake on interrupt
        wr(8'h87, 8'h01);
        tick(0);
        `CHK(cpu_clk_en, 1'b0)
        `CHK(periph_clk_en, 1'b1)
        `CHK(osc_en, 1'b1)
        rd(8'h87, 8'h01);
        @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        tick(0);
        `CHK(cpu_clk_en, 1'b1)
        // Power-down ignores interrupts
        wr(8'h87, 8'h03);
        tick(0);
        `CHK(osc_en, 1'b0)
        `CHK(periph_clk_en, 1'b0)
        `CHK(cpu_clk_en, 1'b0)
        @(posedge clk);
        irq <= 1'b1;
        count_hi(24, 1'b1, cnt);
        `CHK(cnt, 0)
        `CHK(osc_en, 1'b0)
        @(posedge clk);
        irq <= 1'b0;
        rst_pin <= 1'b1;
        wait_rst(1'b1);
        tick(1);
        `CHK(osc_en, 1'b1)
        tick(36);
        @(posedge clk);
        rst_pin <= 1'b0;
        wait_rst(1'b0);
        // Writer pin pattern
        @(posedge clk);
        flash_mode <= 1'b1;
        wr_ale <= 1'b0;
        wr_prog_store_strobe_n <= 1'b1;
        tick(3);
        `CHK(flash_ale_sel, 1'b1)
        `CHK(flash_prog_store_strobe_n_sel, 1'b1)
        `CHK(ale_drv.oe_n, 1'b1)
        `CHK(prog_store_strobe_n_drv.oe_n, 1'b1)
        @(posedge clk);
        wr_ale <= 1'b1;
        wr_prog_store_strobe_n <= 1'b0;
        tick(3);
        `CHK(flash_ale_sel, 1'b0)
        `CHK(flash_prog_store_strobe_n_sel, 1'b0)
        tick(2);
        results();
    end
endmodule : clock_power_reset_control_tb
